/* File: verif/cbts_bit_timing_properties.sv */
// port-level checker for the bit timing block
`timescale 1ns/1ps
module cbts_bit_timing_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_bit,
	input wire logic sample_valid,
	input wire logic bit_start,
	input wire logic sample_point,
	input wire logic tq_tick
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// one wait state, then a single answer cycle
	a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("late apb answer");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
	a_err_unmapped: assert property (pready && paddr >= 12'h008 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	// quantum every four clocks
	a_tick_period: assert property (tq_tick |=> !tq_tick [*3] ##1 tq_tick) else $error("bad tick");
	a_phase_two_max: assert property (sample_point |-> ##[1:36] bit_start) else $error("phase two long");
	a_bit_head_max: assert property (bit_start |-> ##[1:72] sample_point) else $error("bit head long");
	// set by a sample point, cleared by the bit start that must follow it
	logic after_sample;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			after_sample <= 1'b0;
		end else if (sample_point) begin
			after_sample <= 1'b1;
		end else if (bit_start) begin
			after_sample <= 1'b0;
		end
	end
	a_sample_once: assert property (sample_point |-> !after_sample) else $error("second sample point in a bit");
	a_start_after: assert property (bit_start |-> after_sample) else $error("bit start before sample point");
	a_valid_at_sample: assert property (sample_valid == sample_point) else $error("valid off sample");
	a_rx_at_sample: assert property (!$stable(rx_bit) |-> sample_valid) else $error("rx moved late");
endmodule // cbts_bit_timing_properties
bind cbts_bit_timing cbts_bit_timing_properties i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_bit(rx_bit),
	.sample_valid(sample_valid), .bit_start(bit_start), .sample_point(sample_point), .tq_tick(tq_tick));

/* File: verif/cbts_can_node.sv */
// far-side can node: one bit on the line per bit time
`timescale 1ns/1ps
module cbts_can_node (
	input wire logic pclk,
	input wire logic bit_start,
	input wire logic next_bit,
	input wire logic glitch,
	output logic can_rx
);
	logic cur_bit = 1'b1;
	// new level right after the sync edge, held for the whole bit
	always @(posedge pclk) begin
		if (bit_start) begin
			cur_bit <= next_bit;
		end
	end
	// a short disturbance that majority sampling, or a single sample that misses it, hides
	assign can_rx = cur_bit ^ glitch;
endmodule // cbts_can_node

/* File: verif/tb_cbts_bit_timing.sv */
// self-checking bench for the bit timing block
`timescale 1ns/1ps
module tb_cbts_bit_timing;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nb = 1'b1, gl = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, can_rx, rx_bit, sample_valid, bit_start, sample_point, tq_tick, wake_activity;
	int fails = 0, check_count = 0;
	always #(cbts_pkg::CLK_PERIOD_NS / 2) pclk = ~pclk;
	cbts_bit_timing i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .can_rx(can_rx),
		.rx_bit(rx_bit), .sample_valid(sample_valid), .bit_start(bit_start), .sample_point(sample_point),
		.tq_tick(tq_tick), .wake_activity(wake_activity));
	cbts_can_node i_node (.pclk(pclk), .bit_start(bit_start), .next_bit(nb), .glitch(gl), .can_rx(can_rx));
	task automatic chk(input string nm, input logic [31:0] exp_v, input logic [31:0] got);
		check_count++;
		if (got !== exp_v) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp_v, got);
		end
	endtask
	// setup, access until pready, then one idle cycle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// clocks from a bit start to its sample point and to the next bit start
	task automatic span(output int sp, output int bs);
		sp = 0;
		@(posedge pclk iff bit_start === 1'b1);
		do begin
			@(posedge pclk);
			sp++;
		end while (sample_point !== 1'b1);
		bs = sp;
		do begin
			@(posedge pclk);
			bs++;
		end while (bit_start !== 1'b1);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// watchdog well beyond the longest run
	initial begin
		repeat (40000) @(posedge pclk);
		fails++;
		wrap_up();
	end
	initial begin
		int sp, bs, p, p1, p2, q;
		logic [31:0] r;
		logic e;
		logic [15:0] w;
		void'($urandom(23));
		q = int'(cbts_pkg::TQ_DIV);
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, cbts_pkg::CFG_OFFSET, 32'h0, r, e);
		chk("cfg reset", 32'(cbts_pkg::CFG_RESET), r);
		apb(1'b1, cbts_pkg::STATUS_OFFSET, 32'hFF, r, e);
		chk("status write err", 32'h1, e);
		apb(1'b0, 12'h008, 32'h0, r, e);
		chk("unmapped err", 32'h1, e);
		chk("unmapped data", 32'h0, r);
		// corners first, then random words
		for (int k = 0; k < 14; k++) begin
			w = (k == 0) ? 16'h0000 : (k == 1) ? 16'hFFFF : (k == 2) ? 16'h003F : (k == 3) ? 16'h0080 :
				16'($urandom());
			apb(1'b1, cbts_pkg::CFG_OFFSET, {16'hA5A5, w}, r, e);
			chk("cfg write err", 32'h0, e);
			apb(1'b0, cbts_pkg::CFG_OFFSET, 32'h0, r, e);
			chk("cfg read", {16'h0, w & cbts_pkg::CFG_WRITE_MASK}, r);
			p = int'(w[2:0]) + 1;
			p1 = int'(w[5:3]) + 1;
			p2 = w[7] ? int'(w[10:8]) + 1 : (p1 > int'(cbts_pkg::IPT_TQ) ? p1 : int'(cbts_pkg::IPT_TQ));
			span(sp, bs);
			span(sp, bs);
			chk("sample offset", 32'(q * (1 + p + p1)), 32'(sp));
			chk("bit length", 32'(q * (1 + p + p1 + p2)), 32'(bs));
			nb <= 1'($urandom());
			@(posedge pclk iff bit_start === 1'b1);
			if (w[6]) begin
				// one flipped quantum at the sample point, outvoted by the two before it
				repeat (sp - 3) @(posedge pclk);
				gl <= 1'b1;
				repeat (2) @(posedge pclk);
				gl <= 1'b0;
			end else begin
				// the two quanta before the sample point flipped, only a single sample survives
				repeat (sp - 10) @(posedge pclk);
				gl <= 1'b1;
				repeat (6) @(posedge pclk);
				gl <= 1'b0;
			end
			@(posedge pclk iff sample_valid === 1'b1);
			chk("rx bit", 32'(nb), 32'(rx_bit));
		end
		// wake filter: dominant must last the filter time, raw mode reacts at once
		nb <= 1'b1;
		apb(1'b1, cbts_pkg::CFG_OFFSET, 32'h1 << cbts_pkg::WAKE_BIT, r, e);
		@(posedge pclk iff bit_start === 1'b1);
		@(posedge pclk);
		gl <= 1'b1;
		repeat (int'(cbts_pkg::WAKE_FILTER_CYCLES)) @(posedge pclk);
		chk("wake filtered", 32'h0, 32'(wake_activity));
		@(posedge pclk);
		chk("wake long", 32'h1, 32'(wake_activity));
		apb(1'b0, cbts_pkg::STATUS_OFFSET, 32'h0, r, e);
		chk("status err", 32'h0, 32'(e));
		chk("status wake", 32'h1, 32'(r[cbts_pkg::STAT_WAKE_BIT]));
		chk("status high", 32'h0, r & 32'hFFFF_FF00);
		gl <= 1'b0;
		apb(1'b1, cbts_pkg::CFG_OFFSET, 32'h0, r, e);
		gl <= 1'b1;
		@(posedge pclk);
		gl <= 1'b0;
		@(posedge pclk);
		chk("wake raw", 32'h1, 32'(wake_activity));
		@(posedge pclk);
		chk("wake drop", 32'h0, 32'(wake_activity));
		wrap_up();
	end
endmodule // tb_cbts_bit_timing

/* File: verilog/cbts_bit_timing.sv */
// can bit timing segments: apb configuration register and nominal bit timer
`timescale 1ns/1ps
module cbts_bit_timing (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic can_rx,
	output logic rx_bit,
	output logic sample_valid,
	output logic bit_start,
	output logic sample_point,
	output logic tq_tick,
	output logic wake_activity
);

	typedef struct packed {
		cbts_pkg::cbts_cfg_t cfg;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [3:0] div_cnt;
		cbts_pkg::cbts_seg_t seg;
		logic [3:0] seg_cnt;
		cbts_pkg::cbts_evt_t evt;
		logic [3:0] wake_cnt;
		logic wake_activity;
	} cbts_state_t;

	cbts_state_t state_reg;
	cbts_state_t state_next;

	logic [3:0] prop_len;
	logic [3:0] ph1_len;
	logic [3:0] ph2_len;
	logic [3:0] seg_len_now;
	logic tick_now;
	logic last_quantum;
	logic access;
	logic [15:0] status_word;

	// segment lengths in quanta from the live configuration
	always_comb begin
		prop_len = cbts_pkg::cbts_seg_len(state_reg.cfg.propagation_length);
		ph1_len = cbts_pkg::cbts_seg_len(state_reg.cfg.phase_one_length);
		if (state_reg.cfg.phase_two_free_select) begin
			ph2_len = cbts_pkg::cbts_seg_len(state_reg.cfg.phase_two_length);
		end else if (ph1_len > cbts_pkg::IPT_TQ) begin
			ph2_len = ph1_len;
		end else begin
			ph2_len = cbts_pkg::IPT_TQ;
		end
	end

	// length of the segment now running
	always_comb begin
		case (state_reg.seg)
			cbts_pkg::seg_sync: seg_len_now = cbts_pkg::ONE_TQ;
			cbts_pkg::seg_prop: seg_len_now = prop_len;
			cbts_pkg::seg_ph1: seg_len_now = ph1_len;
			cbts_pkg::seg_ph2: seg_len_now = ph2_len;
			default: seg_len_now = cbts_pkg::ONE_TQ;
		endcase
	end

	// quantum divider; prescaler tuning lives elsewhere, so the ratio is fixed here
	assign tick_now = (state_reg.div_cnt == (cbts_pkg::TQ_DIV - cbts_pkg::ONE_TQ));
	// at or past the end, so a write that shortens the running segment ends it at the next tick
	assign last_quantum = (state_reg.seg_cnt >= (seg_len_now - cbts_pkg::ONE_TQ));

	// access phase on the first cycle only; pready comes one cycle later from a flop
	assign access = psel & penable & ~state_reg.pready;

	// read-only view of the timer
	always_comb begin
		status_word = 16'h0000;
		status_word[cbts_pkg::STAT_SEG_LSB +: 2] = state_reg.seg;
		status_word[cbts_pkg::STAT_RX_BIT] = rx_bit;
		status_word[cbts_pkg::STAT_WAKE_BIT] = state_reg.wake_activity;
		status_word[cbts_pkg::STAT_CNT_LSB +: 4] = state_reg.seg_cnt;
	end

	// next state: bus slave, quantum divider, segment sequencer, wake filter
	always_comb begin
		state_next = state_reg;
		state_next.evt = '0;
		state_next.pready = 1'b0;

		// apb: answer after one wait state, write lands with pready
		if (access) begin
			state_next.pready = 1'b1;
			state_next.pslverr = 1'b0;
			state_next.prdata = 32'h0000_0000;
			if (paddr == cbts_pkg::CFG_OFFSET) begin
				state_next.prdata = {16'h0000, cbts_pkg::cbts_pack(state_reg.cfg)};
			end else if (paddr == cbts_pkg::STATUS_OFFSET) begin
				state_next.pslverr = pwrite;
				state_next.prdata = {16'h0000, status_word};
			end else begin
				state_next.pslverr = 1'b1;
			end
		end
		if (psel & penable & state_reg.pready & pwrite & ~state_reg.pslverr & (paddr == cbts_pkg::CFG_OFFSET)) begin
			// new lengths apply from the next quantum boundary check
			state_next.cfg = cbts_pkg::cbts_unpack(pwdata[15:0] & cbts_pkg::CFG_WRITE_MASK);
		end

		// quantum divider
		if (tick_now) begin
			state_next.div_cnt = 4'h0;
			state_next.evt.tq_tick = 1'b1;
		end else begin
			state_next.div_cnt = state_reg.div_cnt + cbts_pkg::ONE_TQ;
		end

		// segment sequencer, one step per quantum
		if (tick_now) begin
			if (last_quantum) begin
				state_next.seg_cnt = 4'h0;
				case (state_reg.seg)
					cbts_pkg::seg_sync: begin
						state_next.seg = cbts_pkg::seg_prop;
					end
					cbts_pkg::seg_prop: begin
						state_next.seg = cbts_pkg::seg_ph1;
					end
					cbts_pkg::seg_ph1: begin
						state_next.seg = cbts_pkg::seg_ph2;
						state_next.evt.sample_point = 1'b1;
					end
					cbts_pkg::seg_ph2: begin
						state_next.seg = cbts_pkg::seg_sync;
						state_next.evt.bit_start = 1'b1;
					end
					default: begin
						state_next.seg = cbts_pkg::seg_sync;
					end
				endcase
			end else begin
				state_next.seg_cnt = state_reg.seg_cnt + cbts_pkg::ONE_TQ;
			end
		end

		// wake-up: raw dominant, or dominant held long enough when filtered
		if (can_rx == cbts_pkg::RECESSIVE) begin
			state_next.wake_cnt = 4'h0;
			state_next.wake_activity = 1'b0;
		end else if (!state_reg.cfg.wake_line_filter_en) begin
			state_next.wake_activity = 1'b1;
		end else if (state_reg.wake_cnt >= (cbts_pkg::WAKE_FILTER_CYCLES - cbts_pkg::ONE_TQ)) begin
			state_next.wake_activity = 1'b1;
		end else begin
			state_next.wake_cnt = state_reg.wake_cnt + cbts_pkg::ONE_TQ;
		end
	end

	// the register has no documented reset value; zero keeps the timer defined
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '{cfg: cbts_pkg::cbts_unpack(cbts_pkg::CFG_RESET), prdata: 32'h0000_0000,
				pready: 1'b0, pslverr: 1'b0, div_cnt: 4'h0, seg: cbts_pkg::seg_sync, seg_cnt: 4'h0,
				evt: '0, wake_cnt: 4'h0, wake_activity: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	// sample point is issued on the tick that ends phase 1
	cbts_sampler u_sampler (
		.pclk(pclk),
		.presetn(presetn),
		.tq_tick(tick_now),
		.sample_point(tick_now & last_quantum & (state_reg.seg == cbts_pkg::seg_ph1)),
		.triple_sel(state_reg.cfg.triple_sample_select),
		.rx_in(can_rx),
		.rx_bit(rx_bit),
		.sample_valid(sample_valid)
	);

	// outputs straight from the state flops
	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign bit_start = state_reg.evt.bit_start;
	assign sample_point = state_reg.evt.sample_point;
	assign tq_tick = state_reg.evt.tq_tick;
	assign wake_activity = state_reg.wake_activity;

endmodule // cbts_bit_timing

/* File: verilog/cbts_pkg.sv */
// shared constants, types and decoders for the can bit timing segment block
package cbts_pkg;

	// system clock
	localparam int unsigned CLK_PERIOD_NS = 100;

	// register map, byte addresses on the apb bus
	localparam logic [11:0] CFG_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;

	// configuration word layout
	localparam int unsigned PROP_LSB = 0;
	localparam int unsigned PH1_LSB = 3;
	localparam int unsigned TRIPLE_BIT = 6;
	localparam int unsigned FREE_BIT = 7;
	localparam int unsigned PH2_LSB = 8;
	localparam int unsigned WAKE_BIT = 14;
	localparam logic [15:0] CFG_WRITE_MASK = 16'h47FF;
	localparam logic [15:0] CFG_RESET = 16'h0000;

	// status word layout
	localparam int unsigned STAT_SEG_LSB = 0;
	localparam int unsigned STAT_RX_BIT = 2;
	localparam int unsigned STAT_WAKE_BIT = 3;
	localparam int unsigned STAT_CNT_LSB = 4;

	// quantum and segment timing
	localparam logic [3:0] TQ_DIV = 4'h4;
	localparam logic [3:0] IPT_TQ = 4'h2;
	localparam logic [3:0] ONE_TQ = 4'h1;

	// wake-up line filter: dominant must persist this long
	localparam int unsigned WAKE_FILTER_NS = 500;
	localparam logic [3:0] WAKE_FILTER_CYCLES = 4'((WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// recessive level of the receive line
	localparam logic RECESSIVE = 1'b1;

	typedef enum logic [1:0] {seg_sync, seg_prop, seg_ph1, seg_ph2} cbts_seg_t;

	typedef struct packed {
		logic wake_line_filter_en;
		logic [2:0] phase_two_length;
		logic phase_two_free_select;
		logic triple_sample_select;
		logic [2:0] phase_one_length;
		logic [2:0] propagation_length;
	} cbts_cfg_t;

	// timing events towards the rest of the controller
	typedef struct packed {
		logic bit_start;
		logic sample_point;
		logic tq_tick;
	} cbts_evt_t;

	// unpack a written configuration word
	function automatic cbts_cfg_t cbts_unpack(input logic [15:0] w);
		cbts_cfg_t c;
		c.wake_line_filter_en = w[WAKE_BIT];
		c.phase_two_length = w[PH2_LSB +: 3];
		c.phase_two_free_select = w[FREE_BIT];
		c.triple_sample_select = w[TRIPLE_BIT];
		c.phase_one_length = w[PH1_LSB +: 3];
		c.propagation_length = w[PROP_LSB +: 3];
		return c;
	endfunction

	// pack configuration for readback, unimplemented bits as zero
	function automatic logic [15:0] cbts_pack(input cbts_cfg_t c);
		logic [15:0] w;
		w = 16'h0000;
		w[WAKE_BIT] = c.wake_line_filter_en;
		w[PH2_LSB +: 3] = c.phase_two_length;
		w[FREE_BIT] = c.phase_two_free_select;
		w[TRIPLE_BIT] = c.triple_sample_select;
		w[PH1_LSB +: 3] = c.phase_one_length;
		w[PROP_LSB +: 3] = c.propagation_length;
		return w;
	endfunction

	// a 3-bit code stands for code plus one quanta
	function automatic logic [3:0] cbts_seg_len(input logic [2:0] code);
		return {1'b0, code} + ONE_TQ;
	endfunction

endpackage

/* File: verilog/cbts_sampler.sv */
// bus line sampler: single or three-sample majority at the sample point
`timescale 1ns/1ps
module cbts_sampler (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tq_tick,
	input wire logic sample_point,
	input wire logic triple_sel,
	input wire logic rx_in,
	output logic rx_bit,
	output logic sample_valid
);

	typedef struct packed {
		logic [1:0] hist;
		logic rx_bit;
		logic sample_valid;
	} cbts_smp_state_t;

	cbts_smp_state_t state_reg;
	cbts_smp_state_t state_next;

	// history holds the line at the two previous quantum ticks
	always_comb begin
		state_next = state_reg;
		state_next.sample_valid = 1'b0;
		if (sample_point) begin
			state_next.sample_valid = 1'b1;
			if (triple_sel) begin
				// majority of three quanta rides out a single glitch
				state_next.rx_bit = (state_reg.hist[1] & state_reg.hist[0]) | (state_reg.hist[1] & rx_in) |
					(state_reg.hist[0] & rx_in);
			end else begin
				state_next.rx_bit = rx_in;
			end
		end
		if (tq_tick) begin
			state_next.hist = {state_reg.hist[0], rx_in};
		end
	end

	// history starts recessive so the first majority is not biased dominant
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '{hist: {cbts_pkg::RECESSIVE, cbts_pkg::RECESSIVE}, rx_bit: cbts_pkg::RECESSIVE,
				sample_valid: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign rx_bit = state_reg.rx_bit;
	assign sample_valid = state_reg.sample_valid;

endmodule // cbts_sampler
